/* cppc_map.svh */
// Constants for the charge pilot pulse controller
`ifndef CPPC_MAP_SVH
`define CPPC_MAP_SVH
// Clock rate and pilot repetition rate
`define CPPC_CLK_HZ 40000000
`define CPPC_PILOT_HZ 1000
// Prescaler: one timer tick per this many clocks (40 MHz / 40 = 1 MHz)
`define CPPC_PRESC_DIV 40
// Ticks per pilot period at the tick rate
`define CPPC_PERIOD_TICKS (`CPPC_CLK_HZ / `CPPC_PRESC_DIV / `CPPC_PILOT_HZ)
// Counter width, signed
`define CPPC_CNT_W 12
// Start value is half the period below zero
`define CPPC_START_VAL (-(`CPPC_PERIOD_TICKS / 2))
// Trigger compare is fixed at zero
`define CPPC_TRIG_VAL 0
// Period end compare: last tick of the period
`define CPPC_END_VAL ((`CPPC_PERIOD_TICKS / 2) - 1)
// Duty limits in ticks per thousand-tick period
`define CPPC_DUTY_MIN 30
`define CPPC_DUTY_MAX 970
`define CPPC_BASIC_MIN 100
`define CPPC_BASIC_MAX 960
`define CPPC_HLC_MIN 30
`define CPPC_HLC_MAX 70
`define CPPC_HLC_DUTY 50
// Reset duty value
`define CPPC_DUTY_RST 50
// Register offsets
`define CPPC_REG_CTRL 4'h0
`define CPPC_REG_DUTY 4'h1
`define CPPC_REG_STAT 4'h2
`define CPPC_REG_LEVEL 4'h3
// Control field positions
`define CPPC_CTRL_ENABLE 0
`define CPPC_CTRL_FAULT 1
`define CPPC_CTRL_HLC 2
`define CPPC_CTRL_TRIGSEL 3
`endif

/* cppc_pkg.sv */
// Types for the charge pilot pulse controller
package cppc_pkg;
  // Classified pilot level from the measuring side
  typedef enum logic [2:0] {
    CPPC_LVL_12V = 3'h0,
    CPPC_LVL_9V = 3'h1,
    CPPC_LVL_6V = 3'h2,
    CPPC_LVL_3V = 3'h3,
    CPPC_LVL_OTHER = 3'h4
  } cppc_level_t;
  // Connection state
  typedef enum logic [1:0] {
    CPPC_ST_A,
    CPPC_ST_B,
    CPPC_ST_C,
    CPPC_ST_ERR
  } cppc_state_t;
  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } cppc_bus_t;
  // Level report from the converter
  typedef struct packed {
    logic valid;
    logic [2:0] code;
  } cppc_meas_t;
endpackage

/* cppc_pilot_ctrl.sv */
// Charge pilot pulse generator, trigger and connection sequencer
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cppc_map.svh"
module cppc_pilot_ctrl
  import cppc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire cppc_bus_t bus_req,
  output logic [15:0] bus_rdata,
  input wire cppc_meas_t meas,
  output logic pilot_pulse_out,
  output logic [1:0] conversion_trigger,
  output logic charging_on
);
  localparam int W = `CPPC_CNT_W;
  typedef logic signed [W-1:0] cppc_cnt_t;

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  // Clamp a programmed duty (per mille) into the accepted range
  function automatic logic [9:0] cppc_clamp(input logic [15:0] d);
    if (d < 16'(`CPPC_DUTY_MIN)) begin
      cppc_clamp = 10'(`CPPC_DUTY_MIN);
    end else if (d > 16'(`CPPC_DUTY_MAX)) begin
      cppc_clamp = 10'(`CPPC_DUTY_MAX);
    end else begin
      cppc_clamp = d[9:0];
    end
  endfunction

  // Half of the ON time in ticks, as a signed count
  function automatic cppc_cnt_t cppc_half(input logic [9:0] d);
    cppc_half = cppc_cnt_t'({2'h0, d} >> 1);
  endfunction

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  logic [3:0] ctrl_reg;
  logic [3:0] ctrl_next;
  logic [9:0] duty_reg;
  logic [9:0] duty_next;
  logic [5:0] presc_reg;
  logic [5:0] presc_next;
  cppc_cnt_t cnt_reg;
  cppc_cnt_t cnt_next;
  cppc_cnt_t rise_reg;
  cppc_cnt_t rise_next;
  cppc_cnt_t fall_reg;
  cppc_cnt_t fall_next;
  cppc_state_t state_reg;
  cppc_state_t state_next;
  logic [2:0] level_reg;
  logic [2:0] level_next;
  logic pulse_reg;
  logic pulse_next;
  logic [1:0] trig_reg;
  logic [1:0] trig_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic trig_pend_reg;
  logic trig_pend_next;

  // -------------------------------------------------------------
  // Register decode
  // -------------------------------------------------------------
  // Write decode with the duty clamped into the accepted range
  wire wr_ctrl = bus_req.wr && bus_req.addr == `CPPC_REG_CTRL;
  wire wr_duty = bus_req.wr && bus_req.addr == `CPPC_REG_DUTY;
  wire enable = ctrl_reg[`CPPC_CTRL_ENABLE];
  wire fault = ctrl_reg[`CPPC_CTRL_FAULT];
  wire hlc = ctrl_reg[`CPPC_CTRL_HLC];
  wire trig_sel = ctrl_reg[`CPPC_CTRL_TRIGSEL];
  assign ctrl_next = wr_ctrl ? bus_req.wdata[3:0] : ctrl_reg;
  assign duty_next = wr_duty ? cppc_clamp(bus_req.wdata) : duty_reg;

  // Read mux, answered in the next cycle; unmapped reads give zero
  logic [15:0] rd_val;
  always_comb begin
    if (bus_req.addr == `CPPC_REG_CTRL) begin
      rd_val = {12'h000, ctrl_reg};
    end else if (bus_req.addr == `CPPC_REG_DUTY) begin
      rd_val = {6'h00, duty_reg};
    end else if (bus_req.addr == `CPPC_REG_STAT) begin
      rd_val = {12'h000, pulse_reg, charging_on, state_reg};
    end else if (bus_req.addr == `CPPC_REG_LEVEL) begin
      rd_val = {13'h0000, level_reg};
    end else begin
      rd_val = 16'h0000;
    end
  end
  // Idle cycles return zero so a stale word is never taken for data
  assign rdata_next = bus_req.rd ? rd_val : 16'h0000;

  // -------------------------------------------------------------
  // Timebase
  // -------------------------------------------------------------
  // One period spans half its ticks below zero to just under half above;
  // the twelve signed bits hold that span without wrapping
  // Prescaler gives one counter tick per microsecond
  wire tick = presc_reg == 6'(`CPPC_PRESC_DIV - 1);
  assign presc_next = tick ? 6'h00 : presc_reg + 6'h01;
  wire at_end = cnt_reg == cppc_cnt_t'(`CPPC_END_VAL);

  // Counter steps per tick and reloads at period end
  assign cnt_next = !tick ? cnt_reg :
                    at_end ? cppc_cnt_t'(`CPPC_START_VAL) :
                    cnt_reg + cppc_cnt_t'(1);

  // Compares are centred on zero and latched only at reload
  wire [9:0] eff_duty = hlc ? 10'(`CPPC_HLC_DUTY) : duty_reg;
  wire load_cmp = tick && at_end;
  assign rise_next = load_cmp ? -cppc_half(eff_duty) : rise_reg;
  assign fall_next = load_cmp ? cppc_half(eff_duty) : fall_reg;

  // -------------------------------------------------------------
  // Connection sequencer
  // -------------------------------------------------------------
  // Level code is taken only when marked valid
  wire lvl_valid = meas.valid;
  assign level_next = lvl_valid ? meas.code : level_reg;
  // A fault wins over every level; clearing it restarts from state A
  always_comb begin
    state_next = state_reg;
    if (fault) begin
      state_next = CPPC_ST_ERR;
    end else begin
      case (state_reg)
        CPPC_ST_A: begin
          if (level_reg == 3'(CPPC_LVL_9V)) begin
            state_next = CPPC_ST_B;
          end else if (level_reg == 3'(CPPC_LVL_6V)) begin
            state_next = CPPC_ST_C;
          end
        end
        CPPC_ST_B: begin
          if (level_reg == 3'(CPPC_LVL_6V)) begin
            state_next = CPPC_ST_C;
          end else if (level_reg == 3'(CPPC_LVL_12V)) begin
            state_next = CPPC_ST_A;
          end
        end
        CPPC_ST_C: begin
          if (level_reg == 3'(CPPC_LVL_9V)) begin
            state_next = CPPC_ST_B;
          end else if (level_reg == 3'(CPPC_LVL_12V)) begin
            state_next = CPPC_ST_A;
          end
        end
        default: begin
          state_next = CPPC_ST_A;
        end
      endcase
    end
  end
  // 3 V and other codes leave the state where it is

  // -------------------------------------------------------------
  // Pilot output and trigger
  // -------------------------------------------------------------
  // Pulses only in state C with the enable set
  // Entering C mid-period keeps the line high until the next fall
  // compare or reload, so the first ON time may be stretched
  wire run = enable && state_reg == CPPC_ST_C;
  wire hit_rise = tick && cnt_reg == rise_reg;
  wire hit_fall = tick && cnt_reg == fall_reg;
  wire hit_trig = tick && cnt_reg == cppc_cnt_t'(`CPPC_TRIG_VAL);
  always_comb begin
    if (state_reg == CPPC_ST_ERR) begin
      pulse_next = 1'b0;
    end else if (!run) begin
      pulse_next = 1'b1;
    end else if (hit_rise) begin
      pulse_next = 1'b1;
    end else if (hit_fall) begin
      pulse_next = 1'b0;
    end else if (load_cmp) begin
      pulse_next = 1'b0;
    end else begin
      pulse_next = pulse_reg;
    end
  end
  // The trigger lags the zero tick by two clocks, which still falls
  // well inside the ON time for every accepted duty
  // Zero-crossing trigger, sent to the selected converter input
  assign trig_pend_next = run && hit_trig;
  assign trig_next = trig_sel ? {trig_pend_reg, 1'b0} :
                     {1'b0, trig_pend_reg};

  // -------------------------------------------------------------
  // State update
  // -------------------------------------------------------------
  // Synchronous reset leaves the pilot high and idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= 4'h0;
      duty_reg <= 10'(`CPPC_DUTY_RST);
      presc_reg <= 6'h00;
      cnt_reg <= cppc_cnt_t'(`CPPC_START_VAL);
      rise_reg <= cppc_cnt_t'(-(`CPPC_DUTY_RST / 2));
      fall_reg <= cppc_cnt_t'(`CPPC_DUTY_RST / 2);
      state_reg <= CPPC_ST_A;
      level_reg <= 3'(CPPC_LVL_12V);
      pulse_reg <= 1'b1;
      trig_pend_reg <= 1'b0;
      trig_reg <= 2'h0;
      rdata_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      duty_reg <= duty_next;
      presc_reg <= presc_next;
      cnt_reg <= cnt_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      state_reg <= state_next;
      level_reg <= level_next;
      pulse_reg <= pulse_next;
      trig_pend_reg <= trig_pend_next;
      trig_reg <= trig_next;
      rdata_reg <= rdata_next;
    end
  end

  // Charging flag registered from state
  logic chg_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chg_reg <= 1'b0;
    end else begin
      chg_reg <= (state_next == CPPC_ST_C) && enable;
    end
  end

  assign pilot_pulse_out = pulse_reg;
  assign conversion_trigger = trig_reg;
  assign bus_rdata = rdata_reg;
  assign charging_on = chg_reg;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  // Every check runs on the system clock and rests during reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_RELOAD: assert property (tick && at_end |=>
    cnt_reg == cppc_cnt_t'(`CPPC_START_VAL))
    else $error("counter did not reload at period end");
  AST_STEP: assert property (tick && !at_end |=>
    cnt_reg == $past(cnt_reg) + cppc_cnt_t'(1))
    else $error("counter did not step on tick");
  AST_ERR_LOW: assert property (state_reg == CPPC_ST_ERR |=>
    !pilot_pulse_out)
    else $error("pilot not low in error");
  AST_IDLE_HIGH: assert property (state_reg == CPPC_ST_A && !fault |=>
    pilot_pulse_out)
    else $error("pilot not high in state A");
  AST_RISE: assert property (run && hit_rise |=> pilot_pulse_out)
    else $error("pilot did not rise at rise compare");
  AST_FALL: assert property (run && hit_fall && !hit_rise |=>
    !pilot_pulse_out)
    else $error("pilot did not fall at fall compare");
  AST_TRIG: assert property (run && hit_trig |=> ##1
    (conversion_trigger != 2'h0) ##1 conversion_trigger == 2'h0)
    else $error("trigger not a single pulse at zero");
  AST_CMP_HOLD: assert property (!load_cmp |=>
    $stable(rise_reg) && $stable(fall_reg))
    else $error("compare changed outside reload");
  AST_DUTY_RANGE: assert property (duty_reg >= 10'(`CPPC_DUTY_MIN) &&
    duty_reg <= 10'(`CPPC_DUTY_MAX))
    else $error("duty outside accepted range");
  AST_B_STOP: assert property (state_reg == CPPC_ST_C && !fault &&
    level_reg == 3'(CPPC_LVL_9V) |=> state_reg == CPPC_ST_B)
    else $error("9 V during charge did not stop pulses");

  // Timebase bounds
  AST_CNT_RANGE: assert property (
    cnt_reg >= cppc_cnt_t'(`CPPC_START_VAL) &&
    cnt_reg <= cppc_cnt_t'(`CPPC_END_VAL))
    else $error("counter outside its period range");
  AST_PRESC_RANGE: assert property (
    presc_reg < 6'(`CPPC_PRESC_DIV))
    else $error("prescaler outside its range");
  AST_TICK_SPACING: assert property (tick |=> !tick)
    else $error("two ticks in a row");
  AST_RELOAD_LOW: assert property (run && load_cmp |=>
    !pilot_pulse_out)
    else $error("pilot not low at period end");

  // Compare values
  AST_CENTRED: assert property (rise_reg == -fall_reg)
    else $error("compares not centred on zero");
  AST_HLC_CMP: assert property (load_cmp && hlc |=>
    fall_reg == cppc_cnt_t'(`CPPC_HLC_DUTY / 2) &&
    rise_reg == cppc_cnt_t'(-(`CPPC_HLC_DUTY / 2)))
    else $error("digital signalling duty not applied at reload");
  AST_DUTY_KEEP: assert property (!wr_duty |=> $stable(duty_reg))
    else $error("duty changed without a write");

  // Trigger checks
  AST_TRIG_SRC: assert property (|conversion_trigger |->
    $past(run && hit_trig, 2))
    else $error("trigger without a zero crossing");
  AST_TRIG_ONEHOT: assert property (|conversion_trigger |->
    $onehot(conversion_trigger))
    else $error("trigger on both selector lines");

  // Sequencer checks
  AST_FAULT_ERR: assert property (fault |=> state_reg == CPPC_ST_ERR)
    else $error("fault did not force the error state");
  AST_ERR_EXIT: assert property (state_reg == CPPC_ST_ERR && !fault |=>
    state_reg == CPPC_ST_A)
    else $error("error state kept after fault cleared");
  AST_A_TO_B: assert property (state_reg == CPPC_ST_A && !fault &&
    level_reg == 3'(CPPC_LVL_9V) |=> state_reg == CPPC_ST_B)
    else $error("9 V in state A did not give state B");
  AST_B_TO_C: assert property (state_reg == CPPC_ST_B && !fault &&
    level_reg == 3'(CPPC_LVL_6V) |=> state_reg == CPPC_ST_C)
    else $error("6 V in state B did not give state C");
  AST_UNPLUG: assert property (state_reg != CPPC_ST_ERR && !fault &&
    level_reg == 3'(CPPC_LVL_12V) |=> state_reg == CPPC_ST_A)
    else $error("12 V did not return to state A");
  AST_HOLD_LOW_LVL: assert property (state_reg != CPPC_ST_ERR &&
    !fault && level_reg >= 3'(CPPC_LVL_3V) |=> $stable(state_reg))
    else $error("unsupported level moved the state");
  AST_CHG_STATE: assert property (charging_on |->
    state_reg == CPPC_ST_C)
    else $error("charging flag outside state C");
  AST_NO_RUN_HIGH: assert property (!run &&
    state_reg != CPPC_ST_ERR |=> pilot_pulse_out)
    else $error("pilot not high while pulses are off");
  AST_LEVEL_TAKE: assert property (meas.valid |=>
    level_reg == $past(meas.code))
    else $error("level code not latched");

  COV_CONNECT: cover property (state_reg == CPPC_ST_A ##1
    state_reg == CPPC_ST_B);
  COV_CHARGE: cover property (run && hit_trig);
  COV_HLC: cover property (run && hlc && hit_trig);
  COV_FAULT: cover property (state_reg == CPPC_ST_ERR);
  COV_UNPLUG: cover property (state_reg == CPPC_ST_C ##1
    state_reg == CPPC_ST_A);
endmodule
`default_nettype wire

/* cppc_far_side.sv */
// Amplifier and level converter model facing the pilot controller
`timescale 1ns/1ps
`default_nettype none
module cppc_far_side
  import cppc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] conversion_trigger,
  input wire cppc_level_t level,
  output var cppc_meas_t meas
);
  logic rep;
  cppc_level_t last_reg;
  // A conversion runs on either selector line or on a level change
  assign rep = (|conversion_trigger) || (level != last_reg);
  // Report one code a cycle after each conversion; scramble it otherwise
  always_ff @(posedge sys_clk) begin
    last_reg <= level;
    meas.valid <= rep && !rst;
    meas.code <= rep ? 3'(level) : 3'(~level);
  end
endmodule
`default_nettype wire

/* charge_pilot_pwm_controller_bench.sv */
// Self-checking bench for the charge pilot pulse controller
`timescale 1ns/1ps
`default_nettype none
`include "cppc_map.svh"
module charge_pilot_pwm_controller_bench
  import cppc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  cppc_bus_t bus_req = '0;
  cppc_level_t lvl = CPPC_LVL_12V;
  cppc_meas_t meas;
  logic [15:0] bus_rdata;
  logic pilot_pulse_out;
  logic [1:0] conversion_trigger;
  logic charging_on;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int d, r1, t1, f1, t2, f2, k;
  // Clock and cycle count
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  cppc_pilot_ctrl dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .meas(meas),
    .pilot_pulse_out(pilot_pulse_out),
    .conversion_trigger(conversion_trigger),
    .charging_on(charging_on)
  );
  cppc_far_side far (
    .sys_clk(sys_clk),
    .rst(rst),
    .conversion_trigger(conversion_trigger),
    .level(lvl),
    .meas(meas)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string w);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, w, got, exp);
    end
  endtask
  // Register bus cycles, one strobe cycle each
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m,
                    input logic [15:0] e, input string w);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk(bus_rdata & m, e, w);
  endtask
  // Bounded wait for pilot (trig=0) or any trigger line (trig=1)
  task automatic wait_for(input bit trig, input logic v, output int at);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while ((trig ? |conversion_trigger : pilot_pulse_out) !== v
               && n < 45000);
    if (n >= 45000) begin
      err_count++;
      $display("[FAIL] %0t wait ran out", $time);
      wrap_up();
    end
    at = cyc;
  endtask
  task automatic hold(input logic v, input int n, input string w);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (pilot_pulse_out !== v) bad++;
    end
    chk(bad, 0, w);
  endtask
  function automatic logic near(int a, int b);
    return (a - b <= 3) && (b - a <= 3);
  endfunction
  function automatic int clks(int ticks);
    return ticks * `CPPC_PRESC_DIV;
  endfunction
  task automatic settle(input cppc_level_t l);
    @(posedge sys_clk);
    lvl <= l;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h520e0212));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(pilot_pulse_out, 1'b1, "idle");
    chk({charging_on, conversion_trigger}, 3'h0, "quiet");
    rd(4'h0, 16'hffff, 16'h0000, "ctrl");
    rd(4'h1, 16'hffff, 16'(`CPPC_DUTY_RST), "duty");
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'hffff, 16'h0000, "unmapped");
    rd(4'h0, 16'hffff, 16'h0000, "ctrl kept");
    $display("reset test done");
    wr(4'h1, 16'h0005);
    rd(4'h1, 16'hffff, 16'(`CPPC_DUTY_MIN), "clamp lo");
    wr(4'h1, 16'h03e7);
    rd(4'h1, 16'hffff, 16'(`CPPC_DUTY_MAX), "clamp hi");
    d = `CPPC_BASIC_MIN + 2 * ($urandom % 430);
    wr(4'h1, 16'(d));
    rd(4'h1, 16'hffff, 16'(d), "duty set");
    $display("duty test done");
    settle(CPPC_LVL_9V);
    rd(4'h2, 16'h0003, 16'h0001, "state b");
    settle(CPPC_LVL_3V);
    rd(4'h2, 16'h0003, 16'h0001, "3v ignored");
    rd(4'h3, 16'h0007, 16'h0003, "level");
    wr(4'h0, 16'h0001);
    hold(1'b1, 400, "b no pulse");
    chk(charging_on, 1'b0, "b idle");
    settle(CPPC_LVL_6V);
    chk(charging_on, 1'b1, "c on");
    rd(4'h2, 16'h0007, 16'h0006, "state c");
    $display("state test done");
    wait_for(1'b0, 1'b0, k);
    wait_for(1'b0, 1'b1, r1);
    wait_for(1'b1, 1'b1, t1);
    chk(conversion_trigger, 2'b01, "trig 0");
    chk(near(t1 - r1, clks(d / 2) + 2), 1'b1, "mid");
    wait_for(1'b0, 1'b0, f1);
    chk(near(f1 - r1, clks(d)), 1'b1, "on time");
    wr(4'h0, 16'h000d);
    wait_for(1'b1, 1'b1, t2);
    chk(conversion_trigger, 2'b10, "trig 1");
    chk(near(t2 - t1, clks(`CPPC_PERIOD_TICKS)), 1'b1, "per");
    wait_for(1'b0, 1'b0, f2);
    k = clks(`CPPC_HLC_DUTY / 2) - 2;
    chk(near(f2 - t2, k), 1'b1, "hlc");
    $display("pulse test done");
    settle(CPPC_LVL_9V);
    chk({charging_on, pilot_pulse_out}, 2'b01, "stop");
    hold(1'b1, 1000, "stay high");
    settle(CPPC_LVL_12V);
    rd(4'h2, 16'h0003, 16'h0000, "state a");
    wr(4'h0, 16'h0003);
    repeat (4) @(posedge sys_clk);
    chk(pilot_pulse_out, 1'b0, "fault low");
    rd(4'h2, 16'h0003, 16'h0003, "err");
    wr(4'h0, 16'h0000);
    repeat (4) @(posedge sys_clk);
    chk(pilot_pulse_out, 1'b1, "a high");
    rd(4'h2, 16'h0003, 16'h0000, "back a");
    wr(4'h0, 16'h0003);
    repeat (4) @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(pilot_pulse_out, 1'b1, "rst high");
    rd(4'h0, 16'hffff, 16'h0000, "ctrl clr");
    $display("fault test done");
    wrap_up();
  end
endmodule
`default_nettype wire
